// ---- lcmcr_pkg.sv ----
// Purpose: shared constants and types for the led channel mask / config register block
// Assumes: byte-wide registers reached over a two-wire smbus target port
// Notes:   offsets are smbus command codes
package lcmcr_pkg;

	// command codes (register offsets)
	localparam logic [7:0] OFS_PWM_BRIGHT  = 8'h00; // smbus pwm brightness
	localparam logic [7:0] OFS_DC_BRIGHT   = 8'h07; // dc brightness
	localparam logic [7:0] OFS_DRIVER_CFG  = 8'h08; // driver_configuration
	localparam logic [7:0] OFS_CH_ENABLE   = 8'h09; // channel_enable_fault_readout

	// reset values
	localparam logic [7:0] RST_DRIVER_CFG  = 8'hFF;
	localparam logic [7:0] RST_CH_ENABLE   = 8'hFF;
	localparam logic [7:0] RST_DC_BRIGHT   = 8'hFF;
	localparam logic [7:0] RST_PWM_BRIGHT  = 8'hFF; // plain default
	localparam logic [7:0] RST_ZERO_BYTE   = 8'h00;

	// field layout of driver_configuration
	localparam int unsigned SHORT_SEL_LSB  = 0; // short_threshold_select[1:0]
	localparam int unsigned FREQ_SEL_BIT   = 2; // switch_freq_select
	localparam logic [1:0]  SHORT_SEL_HIGH = 2'h3; // about 8 V
	localparam logic [1:0]  SHORT_SEL_LOW  = 2'h0; // about 3.1 V

	// bit counter limits
	localparam logic [2:0]  BIT_LAST       = 3'h7;
	localparam logic [2:0]  BIT_FIRST      = 3'h0;
	localparam int unsigned BYTE_MSB       = 7;
	localparam int unsigned ADDR_LSB       = 1;

	// short detection mode
	typedef enum logic [1:0] {
		LCMCR_SHORT_OFF,
		LCMCR_SHORT_LOW,
		LCMCR_SHORT_HIGH
	} lcmcr_short_t;

	// smbus target sequencer
	typedef enum logic [3:0] {
		LCMCR_IDLE,
		LCMCR_ADDR,
		LCMCR_ADDR_ACK,
		LCMCR_CMD,
		LCMCR_CMD_ACK,
		LCMCR_WDATA,
		LCMCR_WDATA_ACK,
		LCMCR_RDATA,
		LCMCR_RD_ACK
	} lcmcr_fsm_t;

	// drive bundle to the analog channel / boost section
	typedef struct packed {
		logic [7:0]   ch_on;      // channel current source on
		lcmcr_short_t short_mode; // short detection threshold
		logic         freq_high;  // 1: 1200 kHz, 0: 600 kHz
		logic [15:0]  dim_level;  // {dc, pwm} combined dimming
	} lcmcr_drive_t;

endpackage

// ---- lcmcr_regs.sv ----
// Purpose: smbus register logic for the configuration and channel mask registers
// Assumes: scl/sda and fault inputs are asynchronous; host uses write/read byte
// Notes:   open-drain sda: sda_oe_o high pulls the line low
// Operation
// - mask bit n governs channel n
// - writing one enables, zero keeps disabled
// - disabled or faulted channels read as zero
// - clear-then-set retries only that channel
// - mask resets to all ones
// - threshold field selects 8 V or 3.1 V
// - config bit two selects 1200/600 kHz
// - pwm and dc combine into 16 bits
// - fixed target address, no strap option
// - a threshold setting disables short detection
// - configuration resets to all ones
`timescale 1ns/1ps
`default_nettype none
module lcmcr_regs
	import lcmcr_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = 7'h2C // fixed address, plain default
)(
	input  wire logic         sys_clk_i,  // 40 MHz system clock
	input  wire logic         reset_n_i,  // async active-low reset
	input  wire logic         clk_en_i,   // freezes all state when low
	input  wire logic         scl_i,      // smbus clock pin
	input  wire logic         sda_i,      // smbus data pin level
	output var  logic         sda_o,      // sda output value, always low
	output var  logic         sda_oe_o,   // pull sda low
	input  wire logic [7:0]   ch_fault_i, // per-channel fault level from analog
	output var  lcmcr_drive_t drive_o     // settings to the analog section
);

	// whole module state
	typedef struct packed {
		logic [2:0]   scl_p;  // scl synchroniser
		logic [2:0]   sda_p;  // sda synchroniser
		logic         scl_f;  // filtered scl
		logic         sda_f;  // filtered sda
		logic [7:0]   flt_p1; // fault synchroniser stage 1
		logic [7:0]   flt_p2; // stage 2
		logic [7:0]   flt_p3; // stage 3
		logic [7:0]   flt_f;  // filtered fault level
		lcmcr_fsm_t   fsm;    // bus sequencer
		logic [2:0]   bcnt;   // bit counter
		logic [7:0]   shreg;  // shift register
		logic [7:0]   cmd;    // command pointer
		logic         rw;     // 1: read transfer
		logic         step;   // ack phase / first read bit marker
		logic         oe;     // sda pull-down
		logic         sdo;    // sda output value
		logic [7:0]   cfg;    // driver_configuration
		logic [7:0]   en;     // stored enable bits
		logic [7:0]   flt;    // latched fault flags
		logic [7:0]   pwm;    // pwm brightness
		logic [7:0]   dc;     // dc brightness
		lcmcr_drive_t drv;    // registered drive bundle
	} lcmcr_state_t;

	// reset image, constants only
	localparam lcmcr_state_t RST_STATE = '{
		scl_p: 3'h7, sda_p: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
		flt_p1: RST_ZERO_BYTE, flt_p2: RST_ZERO_BYTE,
		flt_p3: RST_ZERO_BYTE, flt_f: RST_ZERO_BYTE,
		fsm: LCMCR_IDLE, bcnt: BIT_FIRST, shreg: RST_ZERO_BYTE,
		cmd: RST_ZERO_BYTE, rw: 1'b0, step: 1'b0, oe: 1'b0, sdo: 1'b0,
		cfg: RST_DRIVER_CFG,
		en: RST_CH_ENABLE,
		flt: RST_ZERO_BYTE, pwm: RST_PWM_BRIGHT, dc: RST_DC_BRIGHT,
		drv: '{ch_on: RST_CH_ENABLE, short_mode: LCMCR_SHORT_HIGH,
			freq_high: 1'b1, dim_level: {RST_DC_BRIGHT, RST_PWM_BRIGHT}}
	};

	lcmcr_state_t state_r;   // registered state
	lcmcr_state_t state_nxt; // next state

	// threshold field decode; mixed codes turn detection off
	function automatic lcmcr_short_t short_decode(input logic [7:0] cfg);
		logic [1:0] sel;
		sel = cfg[SHORT_SEL_LSB +: 2];
		if (sel == SHORT_SEL_HIGH)
			return LCMCR_SHORT_HIGH;
		else if (sel == SHORT_SEL_LOW)
			return LCMCR_SHORT_LOW;
		else
			return LCMCR_SHORT_OFF;
	endfunction

	// filtered level follows only when stages two and three agree
	function automatic logic agree(input logic s2, input logic s3, input logic cur);
		return (s2 == s3) ? s2 : cur;
	endfunction

	// register read mux; unmapped codes read zero
	function automatic logic [7:0] read_mux(input lcmcr_state_t s);
		case (s.cmd)
			OFS_PWM_BRIGHT: return s.pwm;
			OFS_DC_BRIGHT:  return s.dc;
			OFS_DRIVER_CFG: return s.cfg;
			OFS_CH_ENABLE:  return s.en & ~s.flt;
			default:        return RST_ZERO_BYTE;
		endcase
	endfunction

	// next-state logic
	always_comb
	begin
		logic       scl_n;     // new filtered scl
		logic       sda_n;     // new filtered sda
		logic       rise;      // scl rising
		logic       fall;      // scl falling
		logic       start;     // start or repeated start
		logic       stop;      // stop condition
		logic [7:0] byte_in;   // byte completed on this edge
		logic       wr_mask;   // host writes channel mask
		logic [7:0] wr_data;   // data of that write
		logic [7:0] clr;       // fault flags to clear
		logic [7:0] evt;       // new fault events
		logic [7:0] rd_byte;   // register under the command pointer
		state_nxt = state_r;
		wr_mask   = 1'b0;
		wr_data   = RST_ZERO_BYTE;
		// locals start defined so no path leaves a latch
		scl_n     = state_r.scl_f;
		sda_n     = state_r.sda_f;
		rise      = 1'b0;
		fall      = 1'b0;
		start     = 1'b0;
		stop      = 1'b0;
		byte_in   = RST_ZERO_BYTE;
		clr       = RST_ZERO_BYTE;
		evt       = RST_ZERO_BYTE;
		// a function result cannot be bit-selected, so hold it here
		rd_byte   = read_mux(state_r);

		// synchronisers: stage one feeds stage two only
		state_nxt.scl_p  = {state_r.scl_p[1:0], scl_i};
		state_nxt.sda_p  = {state_r.sda_p[1:0], sda_i};
		scl_n = agree(state_r.scl_p[1], state_r.scl_p[2], state_r.scl_f);
		sda_n = agree(state_r.sda_p[1], state_r.sda_p[2], state_r.sda_f);
		state_nxt.scl_f  = scl_n;
		state_nxt.sda_f  = sda_n;
		state_nxt.flt_p1 = ch_fault_i;
		state_nxt.flt_p2 = state_r.flt_p1;
		state_nxt.flt_p3 = state_r.flt_p2;
		for (int i = 0; i < 8; i++)
			state_nxt.flt_f[i] = agree(state_r.flt_p2[i], state_r.flt_p3[i],
				state_r.flt_f[i]);

		rise    = ~state_r.scl_f & scl_n;
		fall    = state_r.scl_f & ~scl_n;
		start   = state_r.scl_f & scl_n & state_r.sda_f & ~sda_n;
		stop    = state_r.scl_f & scl_n & ~state_r.sda_f & sda_n;
		byte_in = {state_r.shreg[BYTE_MSB-1:0], sda_n};

		// bus sequencer; start and stop override any phase
		if (start)
		begin
			state_nxt.fsm  = LCMCR_ADDR;
			state_nxt.bcnt = BIT_FIRST;
			state_nxt.step = 1'b0;
			state_nxt.oe   = 1'b0;
		end
		else if (stop)
		begin
			state_nxt.fsm = LCMCR_IDLE;
			state_nxt.oe  = 1'b0;
		end
		else if (rise)
		begin
			case (state_r.fsm)
				LCMCR_ADDR, LCMCR_CMD, LCMCR_WDATA:
				begin
					// sample one bit, msb first
					state_nxt.shreg = byte_in;
					state_nxt.bcnt  = state_r.bcnt + 3'h1;
					if (state_r.bcnt == BIT_LAST)
					begin
						state_nxt.step = 1'b0;
						case (state_r.fsm)
							LCMCR_ADDR:
							begin
								// only the one fixed address is answered
								if (byte_in[BYTE_MSB:ADDR_LSB] == TARGET_ADDR)
								begin
									state_nxt.rw  = byte_in[0];
									state_nxt.fsm = LCMCR_ADDR_ACK;
								end
								else
									state_nxt.fsm = LCMCR_IDLE;
							end
							LCMCR_CMD:
							begin
								state_nxt.cmd = byte_in;
								state_nxt.fsm = LCMCR_CMD_ACK;
							end
							default:
							begin
								// register write
								state_nxt.fsm = LCMCR_WDATA_ACK;
								case (state_r.cmd)
									OFS_PWM_BRIGHT: state_nxt.pwm = byte_in;
									OFS_DC_BRIGHT:  state_nxt.dc  = byte_in;
									OFS_DRIVER_CFG: state_nxt.cfg = byte_in;
									OFS_CH_ENABLE:
									begin
										wr_mask = 1'b1;
										wr_data = byte_in;
									end
									default: ; // unmapped write ignored
								endcase
							end
						endcase
					end
				end
				LCMCR_RDATA:
				begin
					// host samples the bit we drive
					state_nxt.bcnt = state_r.bcnt + 3'h1;
					if (state_r.bcnt == BIT_LAST)
						state_nxt.fsm = LCMCR_RD_ACK;
				end
				LCMCR_RD_ACK:
				begin
					// host ack asks for another byte, nack ends
					if (sda_n)
						state_nxt.fsm = LCMCR_IDLE;
					else
					begin
						state_nxt.fsm   = LCMCR_RDATA;
						state_nxt.bcnt  = BIT_FIRST;
						state_nxt.shreg = read_mux(state_r);
						state_nxt.step  = 1'b1;
					end
				end
				default: ;
			endcase
		end
		else if (fall)
		begin
			case (state_r.fsm)
				LCMCR_ADDR_ACK, LCMCR_CMD_ACK, LCMCR_WDATA_ACK:
				begin
					if (!state_r.step)
					begin
						// first fall: pull sda low for ack
						state_nxt.step = 1'b1;
						state_nxt.oe   = 1'b1;
					end
					else
					begin
						// second fall: release and move on
						state_nxt.step = 1'b0;
						state_nxt.oe   = 1'b0;
						state_nxt.bcnt = BIT_FIRST;
						case (state_r.fsm)
							LCMCR_ADDR_ACK:
							begin
								if (state_r.rw)
								begin
									state_nxt.fsm   = LCMCR_RDATA;
									state_nxt.shreg = rd_byte;
									state_nxt.oe    = ~rd_byte[BYTE_MSB];
								end
								else
									state_nxt.fsm = LCMCR_CMD;
							end
							LCMCR_CMD_ACK: state_nxt.fsm = LCMCR_WDATA;
							default:       state_nxt.fsm = LCMCR_IDLE; // one byte per write
						endcase
					end
				end
				LCMCR_RDATA:
				begin
					// put next bit on the line; first bit after a host ack unshifted
					if (state_r.step)
					begin
						state_nxt.step = 1'b0;
						state_nxt.oe   = ~state_r.shreg[BYTE_MSB];
					end
					else
					begin
						state_nxt.shreg = {state_r.shreg[BYTE_MSB-1:0], 1'b0};
						state_nxt.oe    = ~state_r.shreg[BYTE_MSB-1];
					end
				end
				LCMCR_RD_ACK: state_nxt.oe = 1'b0; // let host drive its ack
				default: ;
			endcase
		end

		// channel mask: bit n is channel n
		if (wr_mask)
			state_nxt.en = wr_data;
		// a zero write clears the fault, so clear-then-set retries that
		// channel alone; a fault in the same cycle as the clear still sets
		clr = wr_mask ? ~wr_data : RST_ZERO_BYTE;
		evt = state_r.flt_f & state_r.en;
		state_nxt.flt = (state_r.flt & ~clr) | evt;

		// registered drive bundle
		state_nxt.drv.ch_on      = state_nxt.en & ~state_nxt.flt;
		state_nxt.drv.short_mode = short_decode(state_nxt.cfg);
		state_nxt.drv.freq_high  = state_nxt.cfg[FREQ_SEL_BIT];
		state_nxt.drv.dim_level  = {state_nxt.dc, state_nxt.pwm};
		state_nxt.sdo            = 1'b0;
	end

	// state register with async reset and clock enable
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_r <= RST_STATE;
		else if (clk_en_i)
			state_r <= state_nxt;
	end

	// outputs straight from flops
	assign sda_o    = state_r.sdo;
	assign sda_oe_o = state_r.oe;
	assign drive_o  = state_r.drv;

endmodule
`default_nettype wire

// ---- lcmcr_props.sv ----
// Purpose: port-level checks of the led channel register block
// Assumes: one clock domain, async active-low reset
// Notes:   attached by bind below
`timescale 1ns/1ps
`default_nettype none
module lcmcr_props
	import lcmcr_pkg::*;
(
	input wire logic         sys_clk_i,
	input wire logic         reset_n_i,
	input wire logic         clk_en_i,
	input wire logic         scl_i,
	input wire logic         sda_i,
	input wire logic         sda_o,
	input wire logic         sda_oe_o,
	input wire logic [7:0]   ch_fault_i,
	input wire lcmcr_drive_t drive_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// open drain: the data value never drives high
	sda_low_a: assert property (sda_o == 1'b0)
		else $error("sda data value not low");
	// settings leave reset at all ones
	reset_vals_a: assert property (
		$rose(reset_n_i) |-> drive_o.ch_on == RST_CH_ENABLE
		&& drive_o.short_mode == LCMCR_SHORT_HIGH && drive_o.freq_high
		&& drive_o.dim_level == 16'hFFFF)
		else $error("drive values wrong after reset");
	// pull-down moves only in the scl low phase
	oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
		else $error("sda pull changed while scl high");
	// writes land late in the scl high phase
	cfg_write_a: assert property (
		$changed({drive_o.short_mode, drive_o.freq_high}) |-> scl_i && $past(scl_i, 2))
		else $error("config drive changed outside a write");
	dim_write_a: assert property ($changed(drive_o.dim_level) |-> scl_i && $past(scl_i, 2))
		else $error("dim level changed outside a write");
	ch_rise_a: assert property (
		(drive_o.ch_on & ~$past(drive_o.ch_on)) != 8'h00 |-> scl_i && $past(scl_i, 2))
		else $error("channel enabled outside a write");
	short_enc_a: assert property (
		drive_o.short_mode inside {LCMCR_SHORT_OFF, LCMCR_SHORT_LOW, LCMCR_SHORT_HIGH})
		else $error("short mode code invalid");
	// a steady fault on a running channel shuts it off; a frozen block waits
	for (genvar g = 0; g < 8; g++)
	begin : g_ch
		fault_off_a: assert property (
			(clk_en_i && ch_fault_i[g] && drive_o.ch_on[g]) [*3] |-> ##[0:4] !drive_o.ch_on[g])
			else $error("faulted channel still on");
	end
endmodule
bind lcmcr_regs lcmcr_props u_props (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .ch_fault_i(ch_fault_i),
	.drive_o(drive_o));
`default_nettype wire

// ---- lcmcr_host.sv ----
// Purpose: behavioural smbus host for the register block
// Assumes: line pulled up, so a released sda reads one
// Notes:   data bits change sda mid low phase, start and stop mid high phase; never beside an scl edge
`timescale 1ns/1ps
`default_nettype none
module lcmcr_host #(
	parameter int HALF = 6 // scl phase in clocks, above the 4 the target needs
)(
	input  wire logic       clk_i,
	input  wire logic       sda_i,
	output var  logic       scl_o,
	output var  logic       sda_o,
	output var  logic [7:0] rd_data_o,
	output var  logic       rd_done_o
);
	logic [8:0] q; // bits seen on the line
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		rd_data_o = 8'h00;
		rd_done_o = 1'b0;
	end
	task automatic hc();
		repeat (HALF) @(negedge clk_i);
	endtask
	// start when s1=1, stop when s1=0
	task automatic cond(input logic s1, input logic s2);
		hc();
		sda_o = s1;
		hc();
		scl_o = 1'b1;
		hc();
		sda_o = s2;
		hc();
		scl_o = ~s1;
	endtask
	// eight bits and the ack slot, msb first
	task automatic bits(input logic [8:0] o);
		for (int i = 8; i >= 0; i--)
		begin
			hc();
			sda_o = o[i];
			hc();
			scl_o = 1'b1;
			hc();
			q[i] = sda_i;
			scl_o = 1'b0;
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic nak);
		cond(1'b1, 1'b0);
		bits({a, 2'b01});
		nak = q[0];
		if (!nak)
		begin
			bits({c, 1'b1});
			bits({d, 1'b1});
		end
		cond(1'b0, 1'b1);
	endtask
	// n bytes: host acks all but the last, which it nacks
	task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n = 1);
		cond(1'b1, 1'b0);
		bits({a, 2'b01});
		bits({c, 1'b1});
		cond(1'b1, 1'b0);
		bits({a, 2'b11});
		for (int k = n; k > 0; k--)
		begin
			bits({8'hFF, k == 1});
			rd_data_o = q[8:1];
			rd_done_o = 1'b1;
			@(negedge clk_i);
			rd_done_o = 1'b0;
		end
		cond(1'b0, 1'b1);
	endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: self-checking bench for the led channel register block
// Assumes: smbus host model as the far side
// Notes:   reads are checked from a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none
module tb import lcmcr_pkg::*;;
	localparam logic [6:0] ADDR = 7'h2C; // design default
	logic         sys_clk  = 1'b0;
	logic         reset_n  = 1'b0;
	logic         clk_en   = 1'b1; // this driver's own enable
	logic [7:0]   ch_fault = 8'h00;
	logic         host_scl, host_sda, dut_oe, dut_sda, rd_done, nak;
	logic [7:0]   rd_data, v;
	lcmcr_drive_t drive;
	logic [7:0]   exp_q[$];
	int           n_errors = 0;
	int           checked  = 0;
	logic [31:0]  seed     = 32'h000154F8;
	wire logic    sda_w    = host_sda & ~dut_oe; // pull-up wins when released
	always #12.5 sys_clk = ~sys_clk;
	lcmcr_regs dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(clk_en),
		.scl_i(host_scl), .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_oe),
		.ch_fault_i(ch_fault), .drive_o(drive));
	lcmcr_host host (.clk_i(sys_clk), .sda_i(sda_w), .scl_o(host_scl), .sda_o(host_sda),
		.rd_data_o(rd_data), .rd_done_o(rd_done));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		v = seed[7:0];
	endtask
	// a multi-byte read repeats the same register
	task automatic rd(input logic [7:0] c, input logic [7:0] e, input int n = 1);
		repeat (n)
			exp_q.push_back(e);
		host.rd(ADDR, c, n);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		host.wr(ADDR, c, d, nak);
		chk("ack", {15'h0000, nak}, 16'h0000);
	endtask
	task automatic pulse(input logic [7:0] f);
		ch_fault = f;
		repeat (6) @(negedge sys_clk);
		ch_fault = 8'h00;
		repeat (8) @(negedge sys_clk);
	endtask
	// each read result against the oldest note
	always @(posedge sys_clk)
		if (rd_done)
			chk("read data", rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
	initial
	begin
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		rd(OFS_CH_ENABLE, RST_CH_ENABLE);
		rd(OFS_DRIVER_CFG, RST_DRIVER_CFG);
		for (int i = 0; i < 4; i++)
		begin
			nxt();
			v[1:0] = i[1:0];
			wr(OFS_DRIVER_CFG, v);
			chk("short", drive.short_mode, i == 3 ? LCMCR_SHORT_HIGH :
				i == 0 ? LCMCR_SHORT_LOW : LCMCR_SHORT_OFF);
			chk("freq", drive.freq_high, v[2]);
			rd(OFS_DRIVER_CFG, v);
		end
		// walking channel, then a random pattern
		for (int i = 0; i < 9; i++)
		begin
			nxt();
			v = i < 8 ? 8'h01 << i : v;
			wr(OFS_CH_ENABLE, v);
			chk("ch on", drive.ch_on, v);
			rd(OFS_CH_ENABLE, v);
		end
		wr(OFS_CH_ENABLE, 8'hFF);
		pulse(8'h08);
		chk("fault off", drive.ch_on, 8'hF7);
		rd(OFS_CH_ENABLE, 8'hF7);
		wr(OFS_CH_ENABLE, 8'hF7);
		pulse(8'h08); // disabled channel must not latch
		chk("others on", drive.ch_on, 8'hF7);
		wr(OFS_CH_ENABLE, 8'hFF);
		chk("retry", drive.ch_on, 8'hFF);
		// enable low freezes the block, so a fault meanwhile is not seen
		clk_en = 1'b0;
		pulse(8'h08);
		chk("frozen", drive.ch_on, 8'hFF);
		clk_en = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			nxt();
			wr(OFS_DC_BRIGHT, seed[15:8]);
			wr(OFS_PWM_BRIGHT, v);
			chk("dim", drive.dim_level, {seed[15:8], v});
		end
		host.wr(ADDR ^ 7'h01, OFS_CH_ENABLE, 8'h00, nak);
		chk("other addr", nak, 1'b1);
		rd(8'h3A, 8'h00); // unmapped reads zero
		rd(OFS_CH_ENABLE, 8'hFF, 2);
		test_done();
	end
	// about 25k cycles of traffic expected
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
